// >>> rtl/dsrc_pkg.sv
package dsrc_pkg;
  // ************************************************************
  // Register word indices
  // ************************************************************
  localparam logic [9:0] REG_SYSTEM_CONTROL = 10'h000;
  localparam logic [9:0] REG_STATUS_FLAGS = 10'h001;
  localparam logic [9:0] REG_STATUS_FLAG_CLEAR = 10'h002;
  localparam logic [9:0] REG_IRQ_ENABLE = 10'h003;
  localparam logic [9:0] REG_MEMORY_MODE = 10'h004;
  localparam logic [9:0] REG_DISPLAY_MODE = 10'h005;
  localparam logic [9:0] REG_RENDERING_MODE = 10'h006;
  localparam logic [9:0] REG_H_ACTIVE_START = 10'h013;
  localparam logic [9:0] REG_H_ACTIVE_END = 10'h014;
  localparam logic [9:0] REG_V_ACTIVE_START = 10'h015;
  localparam logic [9:0] REG_V_ACTIVE_END = 10'h016;
  localparam logic [9:0] REG_HSYNC_WIDTH = 10'h017;
  localparam logic [9:0] REG_H_CYCLE = 10'h018;
  localparam logic [9:0] REG_VSYNC_POSITION = 10'h019;
  localparam logic [9:0] REG_V_CYCLE = 10'h01A;
  localparam logic [9:0] REG_DISPLAY_OFF_COLOR = 10'h01B;
  localparam logic [9:0] REG_BACKDROP_ORIGIN_X = 10'h026;
  localparam logic [9:0] REG_BACKDROP_ORIGIN_Y = 10'h027;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [15:0] RST_SYSTEM_CONTROL = 16'hC000;
  localparam logic [15:0] RST_STATUS_FLAGS = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] STATUS_CLEARABLE = 16'hFE00;
  localparam int SYS_DISPLAY_OUTPUT_ENABLE = 13;
  localparam int ST_FRAME_PARITY_FLAG = 14;
  localparam int ST_VERTICAL_BLANK_FLAG = 11;
  localparam int ST_LIST_END_FLAG = 10;
  localparam int DM_BACKGROUND_COMBINE = 10;
  localparam int DM_SCROLL_ROLLOVER = 11;
  localparam int DM_SCAN_LSB = 4;
  localparam int DM_SYNC_LSB = 6;
  localparam int RM_PIXEL_DEPTH_SELECT = 0;

  // ************************************************************
  // Modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    SCAN_NON_INTERLACE = 2'b00,
    SCAN_INTERLACE = 2'b01,
    SCAN_INTERLACE_VIDEO = 2'b10,
    SCAN_RESERVED = 2'b11
  } dsrc_scan_t;

  typedef enum logic [1:0] {
    SYNC_INTERNAL = 2'b00,
    SYNC_EXTERNAL = 2'b01,
    SYNC_SWITCHING = 2'b10,
    SYNC_RESERVED = 2'b11
  } dsrc_sync_t;

  typedef enum logic [1:0] {
    RCH_IDLE = 2'b00,
    RCH_CAS = 2'b01,
    RCH_RAS = 2'b10,
    RCH_PRECHARGE = 2'b11
  } dsrc_rch_t;

  typedef struct packed {
    logic [15:0] h_cycle;
    logic [15:0] hsync_width;
    logic [15:0] h_active_start;
    logic [15:0] h_active_end;
    logic [15:0] v_cycle;
    logic [15:0] vsync_position;
    logic [15:0] v_active_start;
    logic [15:0] v_active_end;
    logic [15:0] display_off_color;
    logic [9:0] backdrop_x_field;
    logic [13:0] backdrop_y_field;
    logic [3:0] memory_recharge_count;
    dsrc_scan_t scan_type;
    dsrc_sync_t external_sync_select;
    logic display_output_enable;
    logic background_combine;
    logic scroll_rollover;
    logic pixel_depth_select;
  } dsrc_cfg_t;

  typedef struct packed {
    logic cas_n;
    logic ras_n;
  } dsrc_mem_t;
endpackage : dsrc_pkg

// >>> rtl/dsrc_top.sv
// Functional notes
// - Display disabled outputs display-off colour
// - Parity and blank flags mark vsync fall
// - Scan type picks non-interlace, interlace, interlace-video
// - Internal interlace drives parity high even, low odd
// - Sync select picks internal or external timing
// - Internal mode generates programmed syncs, aligned pixels
// - External mode times from hsync fall, vsync rise
// - External mode refresh follows external syncs only
// - Recharge count gives refreshes per raster, zero none
// - CAS-before-RAS refresh from active window fall
// - Background combine only at 8 bits, bit 11 wraps
// - Transparent zero frame pixel shows background pixel
// - Backdrop origin is 10-bit X, 14-bit Y
// - Rollover bit selects simple or wraparound scrolling
// - Reset loads documented register reset values
// - Vertical blank bit 11, list end bit 10
module dsrc_top (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic dot_clk_in,
  input wire logic cpu_cs_n_in,
  input wire logic cpu_rd_n_in,
  input wire logic cpu_we_n_in,
  input wire logic [9:0] cpu_addr_in,
  input wire logic [15:0] cpu_data_in,
  output logic [15:0] cpu_data_out,
  output logic cpu_data_oe_out,
  input wire logic list_end_event_in,
  input wire logic hsync_in,
  output logic hsync_out,
  output logic hsync_oe_out,
  input wire logic vsync_in,
  output logic vsync_out,
  output logic vsync_oe_out,
  input wire logic field_parity_pin_in,
  output logic field_parity_pin_out,
  output logic field_parity_pin_oe_out,
  input wire logic [15:0] frame_pixel_in,
  input wire logic [7:0] bg_pixel_in,
  output logic [15:0] pixel_out,
  output logic active_video_window_out,
  output logic [9:0] backdrop_x_out,
  output logic [13:0] backdrop_y_out,
  output dsrc_pkg::dsrc_mem_t mem_refresh_out
);
  import dsrc_pkg::*;

  // ************************************************************
  // Reset release, system domain
  // ************************************************************
  logic rst_sync1;
  logic rst_n;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // ************************************************************
  // CPU pin synchronisers
  // ************************************************************
  logic [28:0] cpu_meta;
  logic [28:0] cpu_pins;
  logic wr_seen;
  logic wr_pulse;
  logic rd_active;
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cpu_meta <= '0;
      cpu_pins <= '0;
      wr_seen <= 1'b0;
    end else begin
      cpu_meta <= {~cpu_cs_n_in, ~cpu_rd_n_in, ~cpu_we_n_in, cpu_addr_in, cpu_data_in};
      cpu_pins <= cpu_meta;
      wr_seen <= cpu_pins[28] & cpu_pins[26];
    end
  end
  // Addr and data settle through the same stages as the strobe
  assign wr_pulse = cpu_pins[28] & cpu_pins[26] & ~wr_seen;
  assign rd_active = cpu_pins[28] & cpu_pins[27] & ~cpu_pins[26];

  logic [9:0] bus_addr;
  logic [15:0] bus_wdata;
  assign bus_addr = cpu_pins[25:16];
  assign bus_wdata = cpu_pins[15:0];

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] system_control;
  logic [15:0] irq_enable;
  logic [15:0] memory_mode;
  logic [15:0] display_mode;
  logic [15:0] rendering_mode;
  logic [15:0] backdrop_origin_x;
  logic [15:0] backdrop_origin_y;
  logic [15:0] timing_regs [8];
  logic [15:0] display_off_color;
  logic cfg_toggle;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      system_control <= RST_SYSTEM_CONTROL;
      irq_enable <= RST_ZERO;
      display_mode <= RST_ZERO;
      memory_mode <= RST_ZERO;
      rendering_mode <= RST_ZERO;
      backdrop_origin_x <= RST_ZERO;
      backdrop_origin_y <= RST_ZERO;
      display_off_color <= RST_ZERO;
      cfg_toggle <= 1'b0;
    end else if (wr_pulse) begin
      cfg_toggle <= ~cfg_toggle;
      unique case (bus_addr)
        REG_SYSTEM_CONTROL: system_control <= bus_wdata;
        REG_IRQ_ENABLE: irq_enable <= bus_wdata;
        REG_MEMORY_MODE: memory_mode <= bus_wdata;
        REG_DISPLAY_MODE: display_mode <= bus_wdata;
        REG_RENDERING_MODE: rendering_mode <= bus_wdata;
        REG_DISPLAY_OFF_COLOR: display_off_color <= bus_wdata;
        REG_BACKDROP_ORIGIN_X: backdrop_origin_x <= {6'h00, bus_wdata[9:0]};
        REG_BACKDROP_ORIGIN_Y: backdrop_origin_y <= {2'h0, bus_wdata[13:0]};
        default: begin
        end
      endcase
    end
  end

  // Timing registers share one generate loop; unaffected by reset
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_timing
      always_ff @(posedge clk_sys_in) begin
        if (wr_pulse && bus_addr == REG_H_ACTIVE_START + 10'(gi)) begin
          timing_regs[gi] <= bus_wdata;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Status flags with event crossings
  // ************************************************************
  logic vblank_toggle;
  logic frame_toggle;
  logic [2:0] vb_sync;
  logic [2:0] fr_sync;
  logic [15:0] status_flags;
  logic vb_event;
  logic fr_event;
  logic [15:0] clear_mask;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      vb_sync <= 3'h0;
      fr_sync <= 3'h0;
    end else begin
      vb_sync <= {vb_sync[1:0], vblank_toggle};
      fr_sync <= {fr_sync[1:0], frame_toggle};
    end
  end
  assign vb_event = vb_sync[1] ^ vb_sync[2];
  assign fr_event = fr_sync[1] ^ fr_sync[2];
  assign clear_mask = (wr_pulse && bus_addr == REG_STATUS_FLAG_CLEAR) ?
                      (bus_wdata & STATUS_CLEARABLE) : RST_ZERO;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      status_flags <= RST_STATUS_FLAGS;
    end else begin
      // Set wins over a clear in the same cycle
      status_flags <= (status_flags & ~clear_mask)
                      | (16'(vb_event) << ST_VERTICAL_BLANK_FLAG)
                      | (16'(fr_event) << ST_FRAME_PARITY_FLAG)
                      | (16'(list_end_event_in) << ST_LIST_END_FLAG);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = RST_ZERO;
    unique case (bus_addr)
      REG_SYSTEM_CONTROL: next_rdata = system_control;
      REG_STATUS_FLAGS: next_rdata = status_flags;
      REG_IRQ_ENABLE: next_rdata = irq_enable;
      REG_MEMORY_MODE: next_rdata = memory_mode;
      REG_DISPLAY_MODE: next_rdata = display_mode;
      REG_RENDERING_MODE: next_rdata = rendering_mode;
      REG_DISPLAY_OFF_COLOR: next_rdata = display_off_color;
      REG_BACKDROP_ORIGIN_X: next_rdata = backdrop_origin_x;
      REG_BACKDROP_ORIGIN_Y: next_rdata = backdrop_origin_y;
      default: begin
        if (bus_addr >= REG_H_ACTIVE_START && bus_addr <= REG_V_CYCLE) begin
          next_rdata = timing_regs[3'(bus_addr - REG_H_ACTIVE_START)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cpu_data_out <= RST_ZERO;
      cpu_data_oe_out <= 1'b0;
    end else begin
      cpu_data_out <= next_rdata;
      cpu_data_oe_out <= rd_active;
    end
  end

  // ************************************************************
  // Configuration bundle toward the dot domain
  // ************************************************************
  dsrc_cfg_t cfg_sys;
  always_comb begin
    cfg_sys.h_active_start = timing_regs[0];
    cfg_sys.h_active_end = timing_regs[1];
    cfg_sys.v_active_start = timing_regs[2];
    cfg_sys.v_active_end = timing_regs[3];
    cfg_sys.hsync_width = timing_regs[4];
    cfg_sys.h_cycle = timing_regs[5];
    cfg_sys.vsync_position = timing_regs[6];
    cfg_sys.v_cycle = timing_regs[7];
    cfg_sys.display_off_color = display_off_color;
    cfg_sys.backdrop_x_field = backdrop_origin_x[9:0];
    cfg_sys.backdrop_y_field = backdrop_origin_y[13:0];
    cfg_sys.memory_recharge_count = display_mode[3:0];
    cfg_sys.scan_type = dsrc_scan_t'(display_mode[DM_SCAN_LSB +: 2]);
    cfg_sys.external_sync_select = dsrc_sync_t'(display_mode[DM_SYNC_LSB +: 2]);
    cfg_sys.display_output_enable = system_control[SYS_DISPLAY_OUTPUT_ENABLE];
    cfg_sys.background_combine = display_mode[DM_BACKGROUND_COMBINE];
    cfg_sys.scroll_rollover = display_mode[DM_SCROLL_ROLLOVER];
    cfg_sys.pixel_depth_select = rendering_mode[RM_PIXEL_DEPTH_SELECT];
  end

  // ************************************************************
  // Dot domain reset and crossings
  // ************************************************************
  logic drst_sync1;
  logic drst_n;
  always_ff @(posedge dot_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drst_sync1 <= 1'b0;
      drst_n <= 1'b0;
    end else begin
      drst_sync1 <= 1'b1;
      drst_n <= drst_sync1;
    end
  end

  logic [2:0] cfg_tgl_sync;
  dsrc_cfg_t cfg;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic hs_d;
  logic vs_d;
  always_ff @(posedge dot_clk_in or negedge drst_n) begin
    if (!drst_n) begin
      cfg_tgl_sync <= 3'h0;
      cfg <= '0;
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      hs_d <= 1'b1;
      vs_d <= 1'b1;
    end else begin
      cfg_tgl_sync <= {cfg_tgl_sync[1:0], cfg_toggle};
      // Bundle is stable long before the toggle arrives
      if (cfg_tgl_sync[1] ^ cfg_tgl_sync[2]) begin
        cfg <= cfg_sys;
      end
      pin_meta <= {hsync_in, vsync_in, field_parity_pin_in};
      pin_sync <= pin_meta;
      hs_d <= pin_sync[2];
      vs_d <= pin_sync[1];
    end
  end

  logic ext_mode;
  logic interlaced;
  logic ext_h_fall;
  logic ext_v_rise;
  assign ext_mode = (cfg.external_sync_select == SYNC_EXTERNAL);
  assign interlaced = (cfg.scan_type == SCAN_INTERLACE) ||
                      (cfg.scan_type == SCAN_INTERLACE_VIDEO);
  assign ext_h_fall = hs_d & ~pin_sync[2];
  assign ext_v_rise = ~vs_d & pin_sync[1];

  // ************************************************************
  // Raster counters
  // ************************************************************
  logic [15:0] h_count;
  logic [15:0] v_count;
  logic even_field;
  logic line_end;
  logic frame_end;
  assign line_end = ext_mode ? ext_h_fall : (h_count >= cfg.h_cycle);
  assign frame_end = ext_mode ? ext_v_rise : (line_end && v_count >= cfg.v_cycle);

  always_ff @(posedge dot_clk_in or negedge drst_n) begin
    if (!drst_n) begin
      h_count <= 16'h0000;
      v_count <= 16'h0000;
      even_field <= 1'b1;
    end else begin
      if (line_end) begin
        h_count <= 16'h0000;
      end else if (h_count != 16'hFFFF) begin
        h_count <= h_count + 16'h0001;
      end
      if (frame_end) begin
        v_count <= 16'h0000;
      end else if (line_end) begin
        v_count <= v_count + 16'h0001;
      end
      if (ext_mode) begin
        even_field <= interlaced ? pin_sync[0] : 1'b1;
      end else if (frame_end) begin
        even_field <= interlaced ? ~even_field : 1'b1;
      end
    end
  end

  // ************************************************************
  // Sync outputs and field parity
  // ************************************************************
  logic vsync_low;
  logic vsync_low_d;
  assign vsync_low = (v_count >= cfg.vsync_position);
  always_ff @(posedge dot_clk_in or negedge drst_n) begin
    if (!drst_n) begin
      hsync_out <= 1'b1;
      vsync_out <= 1'b1;
      hsync_oe_out <= 1'b0;
      vsync_oe_out <= 1'b0;
      field_parity_pin_out <= 1'b0;
      field_parity_pin_oe_out <= 1'b0;
      // Seen as low already: unprogrammed timing sets no flag
      vsync_low_d <= 1'b1;
      vblank_toggle <= 1'b0;
      frame_toggle <= 1'b0;
    end else begin
      hsync_out <= ~(h_count <= cfg.hsync_width);
      vsync_out <= ~vsync_low;
      hsync_oe_out <= ~ext_mode;
      vsync_oe_out <= ~ext_mode;
      field_parity_pin_out <= even_field;
      field_parity_pin_oe_out <= ~ext_mode & interlaced;
      vsync_low_d <= vsync_low;
      // Same vsync position marks the flags in either sync method
      if (vsync_low && !vsync_low_d) begin
        vblank_toggle <= ~vblank_toggle;
        if (even_field || !interlaced) begin
          frame_toggle <= ~frame_toggle;
        end
      end
    end
  end

  // ************************************************************
  // Active window and backdrop addressing
  // ************************************************************
  logic window_now;
  logic window_d;
  logic [10:0] bg_x_sum;
  logic [14:0] bg_y_sum;
  logic bg_visible;
  assign window_now = (h_count >= cfg.h_active_start) && (h_count < cfg.h_active_end) &&
                      (v_count >= cfg.v_active_start) && (v_count < cfg.v_active_end);
  assign bg_x_sum = {1'b0, cfg.backdrop_x_field} + 11'(h_count - cfg.h_active_start);
  assign bg_y_sum = {1'b0, cfg.backdrop_y_field} + 15'(v_count - cfg.v_active_start);
  // Simple scrolling runs off the edge; rollover folds back
  assign bg_visible = cfg.scroll_rollover || !(bg_x_sum[10] || bg_y_sum[14]);

  logic bg_show;
  always_ff @(posedge dot_clk_in or negedge drst_n) begin
    if (!drst_n) begin
      window_d <= 1'b0;
      active_video_window_out <= 1'b0;
      backdrop_x_out <= 10'h000;
      backdrop_y_out <= 14'h0000;
      bg_show <= 1'b0;
    end else begin
      window_d <= window_now;
      active_video_window_out <= window_now;
      backdrop_x_out <= bg_x_sum[9:0];
      backdrop_y_out <= bg_y_sum[13:0];
      bg_show <= bg_visible;
    end
  end

  // ************************************************************
  // Pixel output
  // ************************************************************
  logic combine_ok;
  assign combine_ok = cfg.background_combine && !cfg.pixel_depth_select;
  always_ff @(posedge dot_clk_in or negedge drst_n) begin
    if (!drst_n) begin
      pixel_out <= 16'h0000;
    end else if (!cfg.display_output_enable) begin
      pixel_out <= cfg.display_off_color;
    end else if (!window_d) begin
      pixel_out <= 16'h0000;
    end else if (combine_ok && bg_show && frame_pixel_in[7:0] == 8'h00) begin
      pixel_out <= {8'h00, bg_pixel_in};
    end else begin
      pixel_out <= frame_pixel_in;
    end
  end

  // ************************************************************
  // Memory recharge sequencer
  // ************************************************************
  // Without external syncs the window never falls again: no refresh
  dsrc_rch_t rch_state;
  dsrc_rch_t next_rch_state;
  logic [3:0] rch_left;
  logic window_fall;
  assign window_fall = window_d && !window_now;

  always_comb begin
    next_rch_state = rch_state;
    unique case (rch_state)
      RCH_IDLE: begin
        if (window_fall && cfg.memory_recharge_count != 4'h0) begin
          next_rch_state = RCH_CAS;
        end
      end
      RCH_CAS: next_rch_state = RCH_RAS;
      RCH_RAS: next_rch_state = RCH_PRECHARGE;
      RCH_PRECHARGE: next_rch_state = (rch_left > 4'h1) ? RCH_CAS : RCH_IDLE;
    endcase
  end

  always_ff @(posedge dot_clk_in or negedge drst_n) begin
    if (!drst_n) begin
      rch_state <= RCH_IDLE;
      rch_left <= 4'h0;
      mem_refresh_out <= '{cas_n: 1'b1, ras_n: 1'b1};
    end else begin
      rch_state <= next_rch_state;
      if (rch_state == RCH_IDLE) begin
        rch_left <= cfg.memory_recharge_count;
      end else if (rch_state == RCH_PRECHARGE) begin
        rch_left <= rch_left - 4'h1;
      end
      // CAS falls one cycle before RAS
      mem_refresh_out.cas_n <= !(next_rch_state == RCH_CAS || next_rch_state == RCH_RAS);
      mem_refresh_out.ras_n <= !(next_rch_state == RCH_RAS);
    end
  end
endmodule // dsrc_top

// >>> test/dsrc_assertions.sv
module dsrc_assertions (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic dot_clk_in,
  input wire logic cpu_cs_n_in,
  input wire logic cpu_rd_n_in,
  input wire logic cpu_data_oe_out,
  input wire logic hsync_oe_out,
  input wire logic field_parity_pin_oe_out,
  input wire logic active_video_window_out,
  input wire dsrc_pkg::dsrc_mem_t mem_refresh_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  // ****
  // Checks
  // ****
  wire cas = mem_refresh_out.cas_n;
  wire ras = mem_refresh_out.ras_n;
  wire rd_act = !cpu_cs_n_in && !cpu_rd_n_in;
  chk_ras_order: assert property (@(posedge dot_clk_in) disable iff (!reset_n_in)
    !ras |-> !cas && $past(ras)) else $error("ras order");
  chk_ras_single: assert property (@(posedge dot_clk_in) disable iff (!reset_n_in)
    !ras |=> ras && cas) else $error("ras length");
  chk_cas_lead: assert property (@(posedge dot_clk_in) disable iff (!reset_n_in)
    !cas && ras |=> !cas && !ras) else $error("cas lead");
  chk_refresh_blank: assert property (@(posedge dot_clk_in) disable iff (!reset_n_in)
    !cas |-> !active_video_window_out) else $error("refresh in window");
  chk_parity_mode: assert property (@(posedge dot_clk_in) disable iff (!reset_n_in)
    field_parity_pin_oe_out |-> hsync_oe_out || $past(hsync_oe_out)) else $error("parity oe");
  chk_read_answer: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(cpu_data_oe_out) |-> $past(rd_act) && $past(rd_act, 2)) else $error("read oe");
  chk_oe_release: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!rd_act) [*5] |-> !cpu_data_oe_out) else $error("oe held");
  chk_reset_quiet: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(reset_n_in) |-> !cpu_data_oe_out) else $error("oe at reset");
  cov_refresh: cover property (@(posedge dot_clk_in) !ras);
  cov_parity: cover property (@(posedge dot_clk_in) field_parity_pin_oe_out);
  cov_read: cover property (@(posedge clk_sys_in) $rose(cpu_data_oe_out));
endmodule // dsrc_assertions

// >>> test/dsrc_sync_gen.sv
module dsrc_sync_gen (
  input wire logic clk_in,
  input wire logic en_in,
  output logic hs_n_out,
  output logic vs_n_out,
  output logic odd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // External sync source
  // ****
  int h = 0;
  int v = 0;
  logic fld = 1'h1;
  always @(posedge clk_in) begin
    h <= (h == 511) ? 0 : h + 1;
    if (h == 511) begin
      v <= (v == 11) ? 0 : v + 1;
      fld <= (v == 11) ? !fld : fld;
    end
  end
  // Plain pulses only; released lines float to the pull-up level
  assign hs_n_out = en_in ? (h >= 4) : 1'h1;
  assign vs_n_out = en_in ? (v >= 3) : 1'h1;
  assign odd_out = en_in ? fld : 1'h1;
endmodule // dsrc_sync_gen

// >>> test/dsrc_top_tb_top.sv
module dsrc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  // ****
  // Bench
  // ****
  localparam logic [9:0] TA [9] = '{REG_H_CYCLE, REG_HSYNC_WIDTH, REG_H_ACTIVE_START,
    REG_H_ACTIVE_END, REG_V_CYCLE, REG_VSYNC_POSITION, REG_V_ACTIVE_START, REG_V_ACTIVE_END,
    REG_DISPLAY_OFF_COLOR};
  localparam logic [15:0] TV [9] = '{16'h01FF, 16'h0003, 16'h0140, 16'h0180, 16'h000B,
    16'h0009, 16'h0002, 16'h0008, 16'h1234};
  logic clk_sys_in = 1'h0, dot_clk_in = 1'h0, reset_n_in = 1'h0, ext = 1'h0;
  logic cpu_cs_n_in = 1'h1, cpu_rd_n_in = 1'h1, cpu_we_n_in = 1'h1, list_end_event_in = 1'h0;
  logic [9:0] cpu_addr_in = 10'h000, backdrop_x_out;
  logic [15:0] cpu_data_in = 16'h0000, frame_pixel_in = 16'h00A5, cpu_data_out, pixel_out;
  logic [7:0] bg_pixel_in = 8'h5A;
  logic [13:0] backdrop_y_out;
  logic cpu_data_oe_out, hsync_out, hsync_oe_out, vsync_out, vsync_oe_out, ghs, gvs, godd;
  logic field_parity_pin_out, field_parity_pin_oe_out, active_video_window_out;
  dsrc_mem_t mem_refresh_out;
  int err_total = 0, total_checks = 0, n;
  wire hsync_in = hsync_oe_out ? hsync_out : ghs;
  wire vsync_in = vsync_oe_out ? vsync_out : gvs;
  wire field_parity_pin_in = field_parity_pin_oe_out ? field_parity_pin_out : godd;
  always #25 clk_sys_in = !clk_sys_in;
  always #16 dot_clk_in = !dot_clk_in;
  dsrc_top u_dut (.*);
  dsrc_sync_gen u_gen (.clk_in(dot_clk_in), .en_in(ext), .hs_n_out(ghs), .vs_n_out(gvs),
    .odd_out(godd));
  task automatic chk(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    cpu_addr_in = a;
    cpu_data_in = d;
    cpu_cs_n_in = 1'h0;
    cpu_we_n_in = 1'h0;
    repeat (5) @(negedge clk_sys_in);
    cpu_we_n_in = 1'h1;
    cpu_cs_n_in = 1'h1;
    repeat (4) @(negedge clk_sys_in);
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] m, e);
    @(negedge clk_sys_in);
    cpu_addr_in = a;
    cpu_cs_n_in = 1'h0;
    cpu_rd_n_in = 1'h0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1 n++;
    end while (cpu_data_oe_out !== 1'h1 && n < 9);
    chk("read_oe", {15'h0000, cpu_data_oe_out}, 16'h0001);
    chk("read", cpu_data_out & m, e);
    @(negedge clk_sys_in);
    cpu_cs_n_in = 1'h1;
    cpu_rd_n_in = 1'h1;
    repeat (5) @(negedge clk_sys_in);
  endtask
  task automatic pix(input logic [15:0] m, e);
    @(posedge active_video_window_out);
    repeat (8) @(posedge dot_clk_in);
    #1 chk("pixel", pixel_out & m, e);
  endtask
  task automatic refs(input logic [15:0] e);
    @(negedge active_video_window_out);
    n = 0;
    repeat (60) begin
      @(posedge dot_clk_in);
      #1 n += !mem_refresh_out.ras_n;
    end
    chk("refresh", 16'(n), e);
  endtask
  task automatic hs_meas;
    @(negedge hsync_out);
    n = 0;
    do begin
      @(posedge dot_clk_in);
      #1 n++;
    end while (hsync_out === 1'h0 && n < 600);
    chk("hs_low", 16'(n), 16'h0004);
    while (hsync_out === 1'h1 && n < 600) begin
      @(posedge dot_clk_in);
      #1 n++;
    end
    chk("hs_cycle", 16'(n), 16'h0200);
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_in);
    reset_n_in = 1'h1;
    repeat (4) @(negedge clk_sys_in);
    rd(REG_SYSTEM_CONTROL, 16'hFFFF, RST_SYSTEM_CONTROL);
    rd(REG_STATUS_FLAGS, 16'hFFFF, RST_STATUS_FLAGS);
    rd(REG_IRQ_ENABLE, 16'hFFFF, RST_ZERO);
    rd(REG_DISPLAY_MODE, 16'hFFFF, RST_ZERO);
    rd(10'h3FF, 16'hFFFF, RST_ZERO);
    for (int i = 0; i < 9; i++) wr(TA[i], TV[i]);
    wr(REG_DISPLAY_MODE, 16'h0003);
    hs_meas();
    refs(16'h0003);
    pix(16'hFFFF, 16'h1234);
    wr(REG_SYSTEM_CONTROL, 16'hE000);
    pix(16'hFFFF, 16'h00A5);
    wr(REG_DISPLAY_MODE, 16'h0403);
    pix(16'h00FF, 16'h00A5);
    chk("bg_x", {6'h00, backdrop_x_out}, 16'h0008);
    frame_pixel_in = 16'h0000;
    pix(16'h00FF, 16'h005A);
    wr(REG_BACKDROP_ORIGIN_Y, 16'hFFFF);
    rd(REG_BACKDROP_ORIGIN_Y, 16'hFFFF, 16'h3FFF);
    wr(REG_BACKDROP_ORIGIN_X, 16'h03FF);
    pix(16'h00FF, 16'h0000);
    wr(REG_DISPLAY_MODE, 16'h0C03);
    pix(16'h00FF, 16'h005A);
    wr(REG_DISPLAY_MODE, 16'h0000);
    refs(16'h0000);
    chk("parity_oe", {15'h0000, field_parity_pin_oe_out}, 16'h0000);
    // Flags cross domains: let a fresh vsync fall settle first
    @(negedge vsync_out);
    repeat (4) @(negedge clk_sys_in);
    list_end_event_in = 1'h1;
    @(negedge clk_sys_in);
    list_end_event_in = 1'h0;
    rd(REG_STATUS_FLAGS, 16'h4C00, 16'h4C00);
    wr(REG_STATUS_FLAG_CLEAR, 16'h4C00);
    rd(REG_STATUS_FLAGS, 16'h4C00, 16'h0000);
    @(negedge vsync_out);
    repeat (4) @(negedge clk_sys_in);
    rd(REG_STATUS_FLAGS, 16'h4C00, 16'h4800);
    wr(REG_DISPLAY_MODE, 16'h0010);
    n = 0;
    repeat (18432) begin
      @(posedge dot_clk_in);
      #1 n |= field_parity_pin_out ? 1 : 2;
    end
    chk("parity", 16'(n), 16'h0003);
    chk("parity_oe", {15'h0000, field_parity_pin_oe_out}, 16'h0001);
    @(negedge clk_sys_in);
    ext = 1'h1;
    wr(REG_DISPLAY_MODE, 16'h0053);
    chk("hs_oe", {14'h0000, hsync_oe_out, vsync_oe_out}, 16'h0000);
    refs(16'h0003);
    wr(REG_DISPLAY_MODE, 16'h0093);
    ext = 1'h0;
    wr(REG_DISPLAY_MODE, 16'h0013);
    chk("hs_oe", {14'h0000, hsync_oe_out, vsync_oe_out}, 16'h0003);
    hs_meas();
    wrap_up();
  end
  // Wide margin: one frame alone is some six thousand dot cycles
  initial begin
    #4000000;
    err_total++;
    wrap_up();
  end
endmodule // dsrc_top_tb_top
bind dsrc_top dsrc_assertions u_chk (.*);
